// *** bench/dcs_remote.sv ***
// Remote controller model feeding the serial ports and the fieldbus option
`timescale 1ns/1ps
`default_nettype none
module dcs_remote (
  input  wire logic         clk, // System clock
  input  wire logic         upd, // Send a fresh set of commands
  output dcs_pkg::dcs_cmd_t p1,  // Keypad RJ-45 port command
  output dcs_pkg::dcs_cmd_t p2,  // Differential pair port command
  output dcs_pkg::dcs_cmd_t fb   // Fieldbus option command
);
  // Output terminal code the configuring party uses for the overheat flag
  localparam int OUT_ASSIGN_OVERHEAT = 56;
  integer seed = 32'h1CD8E634;

  initial begin
    p1 = '0;
    p2 = '0;
    fb = '0;
  end

  // ==========================================================
  // Commands change only when asked, so each port holds its last frame
  always @(posedge clk) begin
    if (upd) begin
      p1 <= 17'($random(seed));
      p2 <= 17'($random(seed));
      fb <= 17'($random(seed));
    end
  end
endmodule : dcs_remote
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the command source and stop mode block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              REF_CLK = 1'b0;
  logic              SYS_RST = 1'b1;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [31:0]       haddr = '0;
  logic [31:0]       hwdata = '0;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic              lnk_pin = 1'b0;
  logic              ramp_done = 1'b0;
  logic              upd = 1'b0;
  logic [9:0]        therm = 10'h000;
  logic [31:0]       hrdata, rd;
  logic              hreadyout, hresp, drive_en, decel_req;
  logic              overheat, alarm_stop;
  dcs_pkg::dcs_cmd_t int_cmd = '0;
  dcs_pkg::dcs_cmd_t p1, p2, fb, cmd_out;
  dcs_pkg::dcs_cmd_t src [4];
  integer            n_mismatch = 0;
  integer            check_count = 0;
  integer            cycles = 0;
  integer            seed = 32'h1CD8E634;

  always #2.5 REF_CLK = ~REF_CLK;

  dcs_core u_dut (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .INT_CMD(int_cmd), .P1_CMD(p1), .P2_CMD(p2),
    .FB_CMD(fb), .LINK_EN_PIN(lnk_pin), .THERM_SENSE(therm),
    .RAMP_DONE(ramp_done), .CMD_OUT(cmd_out), .DRIVE_EN(drive_en),
    .DECEL_REQ(decel_req), .MOTOR_OVERHEAT(overheat),
    .ALARM_STOP(alarm_stop)
  );

  dcs_remote u_remote (.clk(REF_CLK), .upd(upd), .p1(p1), .p2(p2), .fb(fb));

  // ==========================================================
  // Reference model of the source table
  function automatic int fsel(input int h, input int f, input int lnk);
    if (lnk == 0) return 0;
    if (f % 2 == 1) return 3;
    case (h)
      1, 3, 7: return 1;
      4, 5, 8: return 2;
      default: return 0;
    endcase
  endfunction : fsel

  function automatic int rsel(input int h, input int f, input int lnk);
    if (lnk == 0) return 0;
    if (f >= 2) return 3;
    case (h)
      2, 3, 5: return 1;
      6, 7, 8: return 2;
      default: return 0;
    endcase
  endfunction : rsel

  // ==========================================================
  // Checking, bus and closing tasks
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : wt

  // Address phase held until ready, then data phase held until ready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= dcs_pkg::HSIZE_WORD;
    @(posedge REF_CLK);
    while (hreadyout !== 1'b1) @(posedge REF_CLK);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge REF_CLK);
    while (hreadyout !== 1'b1) @(posedge REF_CLK);
    rd = hrdata;
  endtask : ahb

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Whole run needs about 700 cycles
  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    int fs, rs, lnk;
    logic seen;
    wt(20);
    SYS_RST <= 1'b0;
    wt(1);
    rdchk("cfg_reset", dcs_pkg::ADDR_CFG, 32'h0);
    rdchk("level_reset", dcs_pkg::ADDR_LEVEL, 32'h0FA);
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h10, 32'h0);
    rdchk("cfg_kept", dcs_pkg::ADDR_CFG, 32'h0);
    for (int h = 0; h < 9; h++) begin
      for (int f = 0; f < 4; f++) begin
        lnk_pin <= 1'($random(seed));
        int_cmd <= 17'($random(seed));
        upd <= 1'b1;
        wt(1);
        upd <= 1'b0;
        ahb(1'b1, dcs_pkg::ADDR_CFG, 32'((h % 2) << 10 | f << 8 | h << 4));
        wt(6);
        lnk = (h % 2 == 0) || (lnk_pin === 1'b1);
        fs = fsel(h, f, lnk);
        rs = rsel(h, f, lnk);
        src = '{int_cmd, p1, p2, fb};
        ahb(1'b0, dcs_pkg::ADDR_STATUS, 32'h0);
        chk("link_eff", 32'(lnk), 32'(rd[7]));
        chk("freq_src", 32'(fs), 32'(rd[3:2]));
        chk("run_src", 32'(rs), 32'(rd[5:4]));
        chk("cmd_out", {src[fs].freq, src[rs].run}, cmd_out);
      end
    end
    ahb(1'b1, dcs_pkg::ADDR_CFG, 32'h390);
    rdchk("source_reserved", dcs_pkg::ADDR_CFG, 32'h380);
    ahb(1'b1, dcs_pkg::ADDR_CFG, 32'h7);
    rdchk("therm_reserved", dcs_pkg::ADDR_CFG, 32'h1);
    for (int s = 0; s < 2; s++) begin
      ahb(1'b1, dcs_pkg::ADDR_CFG, 32'(s));
      int_cmd <= '0;
      ramp_done <= 1'b1;
      wt(4);
      ramp_done <= 1'b0;
      int_cmd <= {16'h1000, 1'b1};
      wt(6);
      chk("drive_on", 32'h1, drive_en);
      int_cmd.run <= 1'b0;
      wt(4);
      chk("drive_after_stop", 32'(s == 0), drive_en);
      chk("decel_after_stop", 32'(s == 0), decel_req);
      ramp_done <= 1'b1;
      wt(4);
      chk("drive_after_ramp", 32'h0, drive_en);
      ramp_done <= 1'b0;
    end
    int_cmd <= {16'h1000, 1'b1};
    wt(6);
    int_cmd.freq <= 16'h0800;
    seen = 1'b0;
    repeat (5) begin
      @(posedge REF_CLK);
      seen = seen | (decel_req === 1'b1);
    end
    chk("decel_on_lower", 32'h1, 32'(seen));
    chk("drive_on_lower", 32'h1, drive_en);
    for (int m = 0; m < 3; m++) begin
      ahb(1'b1, dcs_pkg::ADDR_CFG, 32'(m << 1));
      therm <= dcs_pkg::LEVEL_RST;
      wt(6);
      chk("flag_at_level", 32'h0, overheat);
      therm <= dcs_pkg::LEVEL_RST + 10'h001;
      wt(6);
      chk("overheat_flag", 32'(m == 2), overheat);
      chk("alarm_stop", 32'(m == 1), alarm_stop);
      chk("drive_thermal", 32'(m != 1), drive_en);
      therm <= 10'h000;
      ahb(1'b1, dcs_pkg::ADDR_CLEAR, 32'h1);
      wt(4);
      chk("alarm_cleared", 32'h0, alarm_stop);
    end
    ahb(1'b1, dcs_pkg::ADDR_LEVEL, 32'h1F5);
    rdchk("level_over", dcs_pkg::ADDR_LEVEL, 32'h0FA);
    ahb(1'b1, dcs_pkg::ADDR_LEVEL, 32'h1F4);
    rdchk("level_max", dcs_pkg::ADDR_LEVEL, 32'h1F4);
    ahb(1'b1, dcs_pkg::ADDR_LEVEL, 32'h0);
    rdchk("level_zero", dcs_pkg::ADDR_LEVEL, 32'h0);
    therm <= 10'h001;
    wt(6);
    chk("overheat_low_level", 32'h1, overheat);
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// *** rtl/dcs_core.sv ***
// Command source routing, stop mode and thermistor guard with AHB-Lite regs
// Notes on behaviour
// - Stop mode 0: run command off ramps motor down by deceleration.
// - Stop mode 1: run command off cuts output drive at once.
// - Lowering frequency while running decelerates, even in coast mode.
// - Thermistor mode 0 off; mode 1 over level trips to alarm stop.
// - Thermistor mode 2 over level raises overheat flag, keeps running.
// - Thermistor monitoring stays active in modes 1 and 2, any motor.
// - Detection level accepted from 0.00 to 5.00 volts.
// - Divided thermistor voltage above level counts as overheat.
// - Serial source picks frequency: 0,2,6 internal; 1,3,7 P1; 4,5,8 P2.
// - Serial source picks run: 0,1,4 internal; 2,3,5 P1; 6,7,8 P2.
// - Fieldbus select overrides: 1 frequency, 2 run, 3 both.
// - Port 1 is the RJ-45 keypad port, port 2 the differential pair.
// - Internal source: frequency selectors or multistep; run by method.
// - Link enable assigned and off forces internal sources.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dcs_core (
  input  wire logic            REF_CLK,     // 200 MHz clock
  input  wire logic            SYS_RST,     // Sync reset, active high
  input  wire logic            HSEL,        // AHB select
  input  wire logic [31:0]     HADDR,       // AHB address
  input  wire logic [1:0]      HTRANS,      // AHB transfer type
  input  wire logic            HWRITE,      // AHB write
  input  wire logic [2:0]      HSIZE,       // AHB size
  input  wire logic [31:0]     HWDATA,      // AHB write data
  input  wire logic            HREADY,      // AHB ready in
  output logic [31:0]          HRDATA,      // AHB read data
  output logic                 HREADYOUT,   // AHB ready out
  output logic                 HRESP,       // AHB response, always OKAY
  input  wire dcs_pkg::dcs_cmd_t INT_CMD,   // Internal selectors
  input  wire dcs_pkg::dcs_cmd_t P1_CMD,    // RJ-45 keypad serial port
  input  wire dcs_pkg::dcs_cmd_t P2_CMD,    // Differential pair port
  input  wire dcs_pkg::dcs_cmd_t FB_CMD,    // Fieldbus option
  input  wire logic            LINK_EN_PIN, // Link operation enable terminal
  input  wire logic [9:0]      THERM_SENSE, // Divided sensor voltage, 10 mV
  input  wire logic            RAMP_DONE,   // Ramp generator reached zero
  output dcs_pkg::dcs_cmd_t    CMD_OUT,     // Selected command
  output logic                 DRIVE_EN,    // Output stage enable
  output logic                 DECEL_REQ,   // Decelerate by ramp settings
  output logic                 MOTOR_OVERHEAT, // Overheat alarm flag
  output logic                 ALARM_STOP   // Protective trip state
);
  // ==========================================================
  // Settings registers
  logic       stop_r;
  logic [1:0] therm_r;
  logic [3:0] ser_r;
  logic [1:0] fb_r;
  logic       lea_r;
  logic [9:0] level_r;

  // ==========================================================
  // Bus slave: one wait state so a read never sees a stale write
  logic       pend_r;
  logic       wr_r;
  logic       map_r;
  logic [7:0] addr_r;
  logic       hready_r;
  logic [31:0] hrdata_r;
  wire        acc = HSEL & HTRANS[1] & HREADY;
  wire        do_wr = pend_r & wr_r & map_r;
  wire        wr_cfg = do_wr & (addr_r == dcs_pkg::ADDR_CFG);
  wire        wr_lvl = do_wr & (addr_r == dcs_pkg::ADDR_LEVEL);
  wire        wr_clr = do_wr & (addr_r == dcs_pkg::ADDR_CLEAR);
  wire [3:0]  ser_in = HWDATA[dcs_pkg::CFG_SER_LSB +: 4];
  wire [9:0]  lvl_in = HWDATA[9:0];

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pend_r   <= 1'b0;
      wr_r     <= 1'b0;
      map_r    <= 1'b0;
      addr_r   <= 8'h00;
      hready_r <= 1'b1;
    end else if (acc) begin
      pend_r   <= 1'b1;
      wr_r     <= HWRITE & (HSIZE == dcs_pkg::HSIZE_WORD);
      map_r    <= (HADDR[31:8] == 24'h000000) & (HADDR[1:0] == 2'h0);
      addr_r   <= HADDR[7:0];
      hready_r <= 1'b0;
    end else begin
      pend_r   <= 1'b0;
      hready_r <= 1'b1;
    end
  end

  // Out-of-range values are refused and the old setting kept
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      stop_r  <= dcs_pkg::STOP_RAMP;
      therm_r <= dcs_pkg::THERM_OFF;
      ser_r   <= 4'h0;
      fb_r    <= 2'h0;
      lea_r   <= 1'b0;
      level_r <= dcs_pkg::LEVEL_RST;
    end else begin
      if (wr_cfg) begin
        stop_r <= HWDATA[dcs_pkg::CFG_STOP_BIT];
        if (HWDATA[dcs_pkg::CFG_THERM_LSB +: 2] != 2'h3)
          therm_r <= HWDATA[dcs_pkg::CFG_THERM_LSB +: 2];
        if (ser_in <= dcs_pkg::SER_MAX)
          ser_r <= ser_in;
        fb_r  <= HWDATA[dcs_pkg::CFG_FB_LSB +: 2];
        lea_r <= HWDATA[dcs_pkg::CFG_LEA_BIT];
      end
      if (wr_lvl && lvl_in <= dcs_pkg::LEVEL_MAX) begin
        level_r <= lvl_in;
      end
    end
  end

  // ==========================================================
  // Link enable terminal: three stages, change taken when 2 and 3 agree
  logic lnk_s1;
  logic lnk_s2;
  logic lnk_s3;
  logic lnk_r;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      lnk_s1 <= 1'b0;
      lnk_s2 <= 1'b0;
      lnk_s3 <= 1'b0;
      lnk_r  <= 1'b0;
    end else begin
      lnk_s1 <= LINK_EN_PIN;
      lnk_s2 <= lnk_s1;
      lnk_s3 <= lnk_s2;
      if (lnk_s2 == lnk_s3)
        lnk_r <= lnk_s3;
    end
  end
  // Unassigned terminal behaves as if on
  wire lnk_eff = ~lea_r | lnk_r;

  // ==========================================================
  // Source decode
  function automatic logic [1:0] freq_src_of(input logic [3:0] v);
    case (v)
      4'h1, 4'h3, 4'h7: freq_src_of = dcs_pkg::SRC_P1;
      4'h4, 4'h5, 4'h8: freq_src_of = dcs_pkg::SRC_P2;
      default:          freq_src_of = dcs_pkg::SRC_INT;
    endcase
  endfunction : freq_src_of

  function automatic logic [1:0] run_src_of(input logic [3:0] v);
    case (v)
      4'h2, 4'h3, 4'h5: run_src_of = dcs_pkg::SRC_P1;
      4'h6, 4'h7, 4'h8: run_src_of = dcs_pkg::SRC_P2;
      default:          run_src_of = dcs_pkg::SRC_INT;
    endcase
  endfunction : run_src_of

  function automatic dcs_pkg::dcs_cmd_t pick(
    input logic [1:0] s,
    input dcs_pkg::dcs_cmd_t a,
    input dcs_pkg::dcs_cmd_t b,
    input dcs_pkg::dcs_cmd_t c,
    input dcs_pkg::dcs_cmd_t d
  );
    case (s)
      dcs_pkg::SRC_P1: pick = b;
      dcs_pkg::SRC_P2: pick = c;
      dcs_pkg::SRC_FB: pick = d;
      default:         pick = a;
    endcase
  endfunction : pick

  wire [1:0] fsrc_ser = freq_src_of(ser_r);
  wire [1:0] rsrc_ser = run_src_of(ser_r);
  wire [1:0] fsrc_sel = ~lnk_eff ? dcs_pkg::SRC_INT :
                        fb_r[0] ? dcs_pkg::SRC_FB : fsrc_ser;
  wire [1:0] rsrc_sel = ~lnk_eff ? dcs_pkg::SRC_INT :
                        fb_r[1] ? dcs_pkg::SRC_FB : rsrc_ser;
  // Port 1 keypad jack, port 2 differential pair, internal selectors
  wire dcs_pkg::dcs_cmd_t f_pick = pick(fsrc_sel, INT_CMD, P1_CMD,
                                        P2_CMD, FB_CMD);
  wire dcs_pkg::dcs_cmd_t r_pick = pick(rsrc_sel, INT_CMD, P1_CMD,
                                        P2_CMD, FB_CMD);
  wire [15:0] sel_freq = f_pick.freq;
  wire        sel_run  = r_pick.run;

  // Registered so a setting change never glitches the outputs
  logic [1:0]  fsrc_r;
  logic [1:0]  rsrc_r;
  logic [15:0] freq_r;
  logic        run_r;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      fsrc_r <= dcs_pkg::SRC_INT;
      rsrc_r <= dcs_pkg::SRC_INT;
      freq_r <= 16'h0000;
      run_r  <= 1'b0;
    end else begin
      fsrc_r <= fsrc_sel;
      rsrc_r <= rsrc_sel;
      freq_r <= sel_freq;
      run_r  <= sel_run;
    end
  end

  // ==========================================================
  // Thermistor guard; independent of which motor is selected
  logic over_r;
  logic trip_r;
  logic ovh_r;
  wire  over = (therm_r != dcs_pkg::THERM_OFF) &
               (THERM_SENSE > level_r);
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      over_r <= 1'b0;
      trip_r <= 1'b0;
      ovh_r  <= 1'b0;
    end else begin
      over_r <= over;
      ovh_r  <= over_r & (therm_r == dcs_pkg::THERM_ALARM);
      // Set wins over a clear in the same cycle
      if (over_r && therm_r == dcs_pkg::THERM_TRIP)
        trip_r <= 1'b1;
      else if (wr_clr && HWDATA[0])
        trip_r <= 1'b0;
    end
  end

  // ==========================================================
  // Stop sequencing
  dcs_pkg::dcs_state_t state_r;
  dcs_pkg::dcs_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dcs_pkg::ST_IDLE: begin
        if (trip_r)
          state_nxt = dcs_pkg::ST_TRIP;
        else if (run_r)
          state_nxt = dcs_pkg::ST_RUN;
      end
      dcs_pkg::ST_RUN: begin
        if (trip_r)
          state_nxt = dcs_pkg::ST_TRIP;
        else if (!run_r && stop_r == dcs_pkg::STOP_COAST)
          state_nxt = dcs_pkg::ST_IDLE;
        else if (!run_r)
          state_nxt = dcs_pkg::ST_RAMP;
      end
      dcs_pkg::ST_RAMP: begin
        if (trip_r)
          state_nxt = dcs_pkg::ST_TRIP;
        else if (run_r)
          state_nxt = dcs_pkg::ST_RUN;
        else if (RAMP_DONE)
          state_nxt = dcs_pkg::ST_IDLE;
      end
      dcs_pkg::ST_TRIP: begin
        if (!trip_r)
          state_nxt = dcs_pkg::ST_IDLE;
      end
      default: state_nxt = dcs_pkg::ST_IDLE;
    endcase
  end

  wire drv_nxt = (state_nxt == dcs_pkg::ST_RUN) |
                 (state_nxt == dcs_pkg::ST_RAMP);
  // Lowered reference while running still follows the ramp
  wire dec_nxt = (state_nxt == dcs_pkg::ST_RAMP) |
                 ((state_nxt == dcs_pkg::ST_RUN) &
                  (sel_freq < freq_r));

  logic drv_r;
  logic dec_r;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_r <= dcs_pkg::ST_IDLE;
      drv_r   <= 1'b0;
      dec_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      drv_r   <= drv_nxt;
      dec_r   <= dec_nxt;
    end
  end

  // ==========================================================
  // Read data
  logic [31:0] stat_w;
  always_comb begin
    stat_w = 32'h00000000;
    stat_w[dcs_pkg::STAT_OVER_BIT]  = over_r;
    stat_w[dcs_pkg::STAT_TRIP_BIT]  = trip_r;
    stat_w[dcs_pkg::STAT_FSRC_LSB +: 2] = fsrc_r;
    stat_w[dcs_pkg::STAT_RSRC_LSB +: 2] = rsrc_r;
    stat_w[dcs_pkg::STAT_DRV_BIT]   = drv_r;
    stat_w[dcs_pkg::STAT_LNK_BIT]   = lnk_eff;
    stat_w[dcs_pkg::STAT_STATE_LSB +: 4] = state_r;
  end
  wire [31:0] cfg_w = {21'h0, lea_r, fb_r, ser_r, 1'b0, therm_r, stop_r};
  wire [31:0] rd_w  = ~map_r ? 32'h00000000 :
    (addr_r == dcs_pkg::ADDR_CFG)    ? cfg_w :
    (addr_r == dcs_pkg::ADDR_LEVEL)  ? {22'h0, level_r} :
    (addr_r == dcs_pkg::ADDR_STATUS) ? stat_w : 32'h00000000;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST)
      hrdata_r <= 32'h00000000;
    else if (pend_r && !wr_r)
      hrdata_r <= rd_w;
  end

  assign HRDATA         = hrdata_r;
  assign HREADYOUT      = hready_r;
  assign HRESP          = 1'b0;
  assign CMD_OUT        = '{freq: freq_r, run: run_r};
  assign DRIVE_EN       = drv_r;
  assign DECEL_REQ      = dec_r;
  assign MOTOR_OVERHEAT = ovh_r;
  assign ALARM_STOP     = trip_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  chk_coast_cut: assert property (
    (state_r == dcs_pkg::ST_RUN && !run_r && !trip_r &&
     stop_r == dcs_pkg::STOP_COAST) |=> !DRIVE_EN && !DECEL_REQ)
    else $error("Coast stop did not cut drive");
  chk_ramp_stop: assert property (
    (state_r == dcs_pkg::ST_RUN && !run_r && !trip_r &&
     stop_r == dcs_pkg::STOP_RAMP) |=> DRIVE_EN && DECEL_REQ)
    else $error("Ramp stop missing");
  chk_lower_decel: assert property (
    (state_r == dcs_pkg::ST_RUN && run_r && !trip_r &&
     sel_freq < freq_r) |=> DECEL_REQ && DRIVE_EN)
    else $error("Lowered reference not decelerated");
  chk_trip_stops: assert property (
    (therm_r == dcs_pkg::THERM_TRIP && over_r) |=> ALARM_STOP ##1 !DRIVE_EN)
    else $error("Overheat trip did not stop drive");
  chk_alarm_flag: assert property (
    MOTOR_OVERHEAT == $past(over_r && therm_r == dcs_pkg::THERM_ALARM))
    else $error("Overheat flag wrong");
  chk_mode_off: assert property (
    (therm_r == dcs_pkg::THERM_OFF) |=> !over_r)
    else $error("Overheat seen with guard off");
  chk_sense_cmp: assert property (
    (therm_r != dcs_pkg::THERM_OFF && THERM_SENSE > level_r) |=> over_r)
    else $error("Level crossing missed");
  chk_level_range: assert property (
    level_r <= dcs_pkg::LEVEL_MAX)
    else $error("Level out of range");
  chk_lnk_internal: assert property (
    !lnk_eff |=> fsrc_r == dcs_pkg::SRC_INT && rsrc_r == dcs_pkg::SRC_INT)
    else $error("Link disable did not force internal");
  chk_ser_route: assert property (
    (lnk_eff && !fb_r[0] && ser_r inside {4'h4, 4'h5, 4'h8})
      |=> fsrc_r == dcs_pkg::SRC_P2)
    else $error("Frequency source wrong");
  chk_run_route: assert property (
    (lnk_eff && !fb_r[1] && ser_r inside {4'h2, 4'h3, 4'h5})
      |=> rsrc_r == dcs_pkg::SRC_P1)
    else $error("Run source wrong");
  chk_fb_both: assert property (
    (lnk_eff && fb_r == 2'h3) |=> fsrc_r == dcs_pkg::SRC_FB &&
                                 rsrc_r == dcs_pkg::SRC_FB)
    else $error("Fieldbus override missing");
  chk_out_follow: assert property (
    CMD_OUT.run == $past(sel_run) && CMD_OUT.freq == $past(sel_freq))
    else $error("Output not registered selection");
endmodule : dcs_core
`default_nettype wire

// *** rtl/dcs_pkg.sv ***
// Constants and types for the drive command source and stop mode block
`default_nettype none
package dcs_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_LEVEL  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CLEAR  = 8'h0C;
  // ==========================================================
  // Field positions in the configuration register
  localparam int CFG_STOP_BIT = 0;
  localparam int CFG_THERM_LSB = 1;
  localparam int CFG_SER_LSB   = 4;
  localparam int CFG_FB_LSB   = 8;
  localparam int CFG_LEA_BIT  = 10;
  // Field positions in the status register
  localparam int STAT_OVER_BIT = 0;
  localparam int STAT_TRIP_BIT = 1;
  localparam int STAT_FSRC_LSB = 2;
  localparam int STAT_RSRC_LSB = 4;
  localparam int STAT_DRV_BIT  = 6;
  localparam int STAT_LNK_BIT  = 7;
  localparam int STAT_STATE_LSB = 8;
  // ==========================================================
  // Values after reset and limits; level is in 10 mV steps
  localparam logic [9:0] LEVEL_RST = 10'h0FA;
  localparam logic [9:0] LEVEL_MAX = 10'h1F4;
  localparam logic [3:0] SER_MAX   = 4'h8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ==========================================================
  // Modes and source codes
  localparam logic       STOP_RAMP  = 1'b0;
  localparam logic       STOP_COAST = 1'b1;
  localparam logic [1:0] THERM_OFF   = 2'h0;
  localparam logic [1:0] THERM_TRIP  = 2'h1;
  localparam logic [1:0] THERM_ALARM = 2'h2;
  localparam logic [1:0] SRC_INT    = 2'h0;
  localparam logic [1:0] SRC_P1     = 2'h1;
  localparam logic [1:0] SRC_P2     = 2'h2;
  localparam logic [1:0] SRC_FB     = 2'h3;
  // ==========================================================
  // Types
  typedef struct packed {
    logic [15:0] freq;
    logic        run;
  } dcs_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_RAMP = 4'b0100,
    ST_TRIP = 4'b1000
  } dcs_state_t;
endpackage : dcs_pkg
`default_nettype wire
